// >>> test/asp_host_model.sv
`timescale 1ns/100ps
module asp_host_model (
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic sdi_out
);
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b1;
    sdi_out = 1'b0;
  end
  // no pull on the data line, so a deselected line keeps toggling
  always @(posedge clk_in) if (cs_n_out) sdi_out <= ~sdi_out;
  // 8 clocks per bit gives 5 MHz and, at 146 clocks per frame, about 274 kSPS
  task automatic xfer(input logic [15:0] w, input logic last, output logic [15:0] r);
    cs_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    for (int i = 15; i >= 0; i--) begin
      sclk_out <= 1'b0;
      sdi_out <= w[i];
      repeat (4) @(posedge clk_in);
      @(negedge clk_in) r = {r[14:0], sdo_in};
      @(posedge clk_in) sclk_out <= 1'b1;
      repeat (3) @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
    if (last) cs_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
endmodule

// >>> test/asp_top_properties.sv
`timescale 1ns/100ps
module asp_chk (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic sdo_out,
  input wire logic sdo_oe_out,
  input wire logic conv_req_out,
  input wire logic [2:0] conv_chan_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence idle_s; cs_n_in [*6]; endsequence
  sequence sel_s; !cs_n_in [*6]; endsequence
  a_oe_idle: assert property (idle_s |-> !sdo_oe_out) else $error("oe idle");
  a_req_idle: assert property (idle_s |-> !conv_req_out) else $error("req idle");
  a_oe_sel: assert property (sel_s |-> sdo_oe_out) else $error("oe off");
  a_req_start: assert property ($fell(cs_n_in) |-> ##[2:6] conv_req_out) else $error("no req");
  a_req_pulse: assert property (conv_req_out |=> !conv_req_out) else $error("req long");
  a_pad_zero: assert property ($rose(sdo_oe_out) |-> !sdo_out) else $error("pad");
  a_sdo_fall: assert property ($changed(sdo_out) && sdo_oe_out && $past(sdo_oe_out) |-> !sclk_in)
    else $error("sdo edge");
  a_chan_rst: assert property ($fell(sys_rst_in) |-> conv_chan_out == 3'h0) else $error("chan");
endmodule
bind asp_top asp_chk chk (.*);

// >>> test/test_adc_serial_sample_port.sv
`timescale 1ns/100ps
module test_adc_serial_sample_port;
  logic ref_clk_in, sys_rst_in, cs_n, sclk, sdi, sdo, sdo_oe, req, valid, ready;
  logic [2:0] chan;
  logic [11:0] cdata;
  logic [15:0] rx;
  int err_count, checks_done, req_count;
  asp_top uut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n), .sclk_in(sclk),
    .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .conv_req_out(req), .conv_chan_out(chan),
    .conv_valid_in(valid), .conv_data_in(cdata), .conv_ready_out(ready));
  asp_host_model host (.clk_in(ref_clk_in), .sdo_in(sdo), .cs_n_out(cs_n), .sclk_out(sclk),
    .sdi_out(sdi));
  // one start request at the chip select fall plus one at the end of every frame
  always @(posedge ref_clk_in) if (req === 1'b1) req_count <= req_count + 1;
  function automatic logic [11:0] val(int k);
    return 12'hfff - 12'(k * 12'h07b);
  endfunction
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic test_fill();
    for (int i = 0; i < 32; i++) begin
      valid <= 1'b1;
      cdata <= val(i);
      @(posedge ref_clk_in);
      while (ready !== 1'b1) @(posedge ref_clk_in);
    end
    cdata <= 12'h000;
    repeat (3) @(posedge ref_clk_in);
    check("ready full", {15'h0000, ready}, 16'h0000);
    valid <= 1'b0;
    $display("test fill done");
  endtask
  // the last frame finds the buffer empty and must carry zeros
  task automatic test_drain();
    check("oe idle", {15'h0000, sdo_oe}, 16'h0000);
    for (int i = 0; i < 33; i++) begin
      host.xfer({2'b00, i[2:0], 11'h000}, i == 32, rx);
      check("frame", rx, {4'h0, i < 32 ? val(i) : 12'h000});
      check("chan", {13'h0000, chan}, {13'h0000, i[2:0]});
      check("oe", {15'h0000, sdo_oe}, {15'h0000, i < 32});
    end
    check("req count", 16'(req_count), 16'h0022);
    $display("test drain done");
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    sys_rst_in = 1'b1;
    valid = 1'b0;
    cdata = 12'h000;
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    test_fill();
    test_drain();
    conclude();
  end
  initial begin
    #400000;
    err_count++;
    conclude();
  end
endmodule

// >>> verilog/asp_consts.svh
`ifndef ASP_CONSTS_SVH
`define ASP_CONSTS_SVH

// serial frame layout
`define ASP_FRAME_BITS 16
`define ASP_RES_BITS 12
`define ASP_CNT_W 5
`define ASP_PAD_BITS 4
// channel field inside the captured control word
`define ASP_CHAN_LSB 11
`define ASP_CHAN_W 3
`define ASP_CHAN_RST 3'h0
// result buffer
`define ASP_FIFO_DEPTH 32
// host-side limits, kept for reference only; the bench does not use them
`define ASP_SCLK_MIN_KHZ 800
`define ASP_SCLK_MAX_KHZ 16000
`define ASP_RATE_MIN_KSPS 50
`define ASP_RATE_MAX_KSPS 1000

`endif

// >>> verilog/asp_pkg.sv
package asp_pkg;
  typedef enum logic [0:0] {
    ASP_IDLE = 1'b0,
    ASP_FRAME = 1'b1
  } asp_state_t;
endpackage

// >>> verilog/asp_top.sv
// Notes on behaviour
// - a falling edge on the chip select starts a conversion.
// - conversions repeat frame after frame while chip select stays low.
// - control bits are taken from the data input on serial clock rising edges.
// - result bits change on the data output at serial clock falling edges.
// - the chip select fall and the serial clock pace conversion; the serial clock alone paces readout.
// - results are sent as plain unsigned binary.
// - every result is 12 bits wide.
// - the channel, 0 to 7, comes from the control word loaded by the host.
`timescale 1ns/100ps
`include "asp_consts.svh"

module asp_fifo #(
  parameter int WIDTH = `ASP_RES_BITS,
  parameter int DEPTH = `ASP_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ready_q, ready_d;
  logic push, pop;

  always_comb begin
    push = in_valid_in && ready_q;
    pop = (cnt_q != '0) && out_ready_in;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    ready_d = cnt_d < (AW+1)'(DEPTH);
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ready_q <= 1'b1;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ready_q <= ready_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  assign in_ready_out = ready_q;
  assign out_valid_out = cnt_q != '0;
  assign out_data_out = mem_q[rd_q];
endmodule

module asp_top #(
  parameter int RES_BITS = `ASP_RES_BITS,
  parameter int FIFO_DEPTH = `ASP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  // serial pins
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic sdi_in,
  output logic sdo_out,
  output logic sdo_oe_out,
  // converter core: request and result
  output logic conv_req_out,
  output logic [`ASP_CHAN_W-1:0] conv_chan_out,
  input wire logic conv_valid_in,
  input wire logic [RES_BITS-1:0] conv_data_in,
  output logic conv_ready_out
);
  // pin synchronisers; stage one is read only by stage two
  logic [2:0] s1_q, s2_q;
  logic sclk_prev_q;
  logic cs_prev_q;
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      s1_q <= 3'h7;
      s2_q <= 3'h7;
      sclk_prev_q <= 1'b1;
      cs_prev_q <= 1'b1;
    end else begin
      s1_q <= {cs_n_in, sclk_in, sdi_in};
      s2_q <= s1_q;
      sclk_prev_q <= s2_q[1];
      cs_prev_q <= s2_q[2];
    end
  end

  logic cs_n_s, sclk_s, sdi_s, sclk_rise, sclk_fall, cs_fall;
  assign cs_n_s = s2_q[2];
  assign sclk_s = s2_q[1];
  assign sdi_s = s2_q[0];
  // serial clock edges and the chip select fall are the timing events of the port
  assign sclk_rise = sclk_s && !sclk_prev_q;
  assign sclk_fall = !sclk_s && sclk_prev_q;
  assign cs_fall = !cs_n_s && cs_prev_q;

  logic fifo_valid, fifo_pop;
  logic [RES_BITS-1:0] fifo_data;
  asp_fifo #(.WIDTH(RES_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(ref_clk_in),
    .rst_in(sys_rst_in),
    .in_valid_in(conv_valid_in),
    .in_data_in(conv_data_in),
    .in_ready_out(conv_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(fifo_pop)
  );

  asp_pkg::asp_state_t st_q, st_d;
  logic [`ASP_CNT_W-1:0] cnt_q, cnt_d;
  logic [`ASP_FRAME_BITS-1:0] tx_q, tx_d, rx_q, rx_d, word;
  logic wrap_q, wrap_d, req_q, req_d, oe_q, oe_d;
  logic [`ASP_CHAN_W-1:0] chan_q, chan_d;

  // unsigned 12-bit result behind four zero pad bits
  assign word = {{`ASP_PAD_BITS{1'b0}}, fifo_valid ? fifo_data : {RES_BITS{1'b0}}};

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    tx_d = tx_q;
    rx_d = rx_q;
    wrap_d = wrap_q;
    req_d = 1'b0;
    chan_d = chan_q;
    fifo_pop = 1'b0;
    oe_d = !cs_n_s;
    if (cs_n_s) begin
      // frame abandoned, clock and data ignored
      st_d = asp_pkg::ASP_IDLE;
      cnt_d = '0;
      wrap_d = 1'b0;
      tx_d = '0;
    end else if (cs_fall || st_q == asp_pkg::ASP_IDLE) begin
      // new conversion on the selected channel
      // a pad zero stands on the pin until the first falling edge loads the word,
      // so every frame bit is launched by a falling edge and read on the rise after
      // it; popping that late also lets a result that has just landed make the frame
      st_d = asp_pkg::ASP_FRAME;
      cnt_d = '0;
      req_d = 1'b1;
      tx_d = '0;
      wrap_d = 1'b1;
    end else begin
      if (sclk_rise) begin
        rx_d = {rx_q[`ASP_FRAME_BITS-2:0], sdi_s};
        if (cnt_q == `ASP_CNT_W'(`ASP_FRAME_BITS - 1)) begin
          // frame complete, next one begins at once
          cnt_d = '0;
          wrap_d = 1'b1;
          req_d = 1'b1;
          chan_d = rx_d[`ASP_CHAN_LSB+:`ASP_CHAN_W];
        end else begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      if (sclk_fall) begin
        if (wrap_q) begin
          // first falling edge of a frame: the word's leading pad bit goes out
          wrap_d = 1'b0;
          tx_d = word;
          fifo_pop = fifo_valid;
        end else begin
          tx_d = {tx_q[`ASP_FRAME_BITS-2:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_q <= asp_pkg::ASP_IDLE;
      cnt_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      wrap_q <= 1'b0;
      req_q <= 1'b0;
      oe_q <= 1'b0;
      chan_q <= `ASP_CHAN_RST;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tx_q <= tx_d;
      rx_q <= rx_d;
      wrap_q <= wrap_d;
      req_q <= req_d;
      oe_q <= oe_d;
      chan_q <= chan_d;
    end
  end

  // an empty buffer sends zeros rather than stalling the host's frame
  assign sdo_out = tx_q[`ASP_FRAME_BITS-1];
  assign sdo_oe_out = oe_q;
  assign conv_req_out = req_q;
  assign conv_chan_out = chan_q;
endmodule
